/* File: src/pdm_ctrl.sv */
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Function
// - watch mode wakes on group one only
// - subsleep wakes on group two sources
// - sleep, subsleep, watch, standby left only on interrupt acceptance
// - standby holds port registers, outputs high-z
// - retained external interrupts ignored, flags held
// - capture timer runs on external or w/4
// - secondary serial runs on w/2; reset
// - display runs on w, w/2, w/4
// - timekeeping runs if time-base; standby holds
// - event counter counts, no interrupt in watch/standby
// - watchdog runs in subactive on w/32
// - event timers, primary serial need w/4
// - standby select plus sleep enters standby/watch
// - wake wait from selected wait field
module pdm_ctrl
  import pdm_pkg::*;
#(
  parameter logic [17:0] WAIT_0 = 18'd8192,
  parameter logic [17:0] WAIT_1 = 18'd16384,
  parameter logic [17:0] WAIT_2 = 18'd32768,
  parameter logic [17:0] WAIT_3 = 18'd65536,
  parameter logic [17:0] WAIT_4 = 18'd131072
) (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESET_N,
  // Avalon-MM register slave.
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // CPU handshake.
  input wire logic SLEEP_REQ,
  input wire logic INT_ACCEPT,
  // Interrupt sources from pins and peripherals.
  input wire logic [PDM_SRC_W-1:0] INT_SRC,
  // Clock, run and reset controls.
  output logic CPU_RUN,
  output logic CPU_ON_SUBCLK,
  output logic SYS_OSC_EN,
  output logic SUB_OSC_EN,
  output logic PORT_HIZ,
  output logic [PDM_PER_W-1:0] RUN_EN,
  output logic [PDM_PER_W-1:0] PERIPH_RST,
  output logic [4:0] EXT_FLAG_HOLD,
  output logic AEC_IRQ_EN,
  output logic WAKE_REQ,
  output logic [2:0] MODE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  // All registered state of the block.
  typedef struct packed {
    logic [PDM_SRC_W-1:0] src_m;
    logic [PDM_SRC_W-1:0] src_s;
    pdm_mode_t mode;
    logic [17:0] wait_cnt;
    logic [5:0] ctrl;
    logic [24:0] clksel;
    logic [PDM_EV_W-1:0] stat;
    logic [PDM_EV_W-1:0] mask;
    logic waitreq;
    logic [31:0] rdata;
    logic wake;
    logic irq;
    logic cpu_run;
    logic on_sub;
    logic sys_osc;
    logic sub_osc;
    logic port_hiz;
    logic [PDM_PER_W-1:0] run_en;
    logic [PDM_PER_W-1:0] rst;
    logic [4:0] ext_hold;
    logic aec_irq_en;
  } pdm_state_t;

  pdm_state_t s_q;
  pdm_state_t s_d;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Picks one 3-bit clock select field.
  function automatic logic [2:0] csel(input logic [24:0] r, input int idx);
    csel = r[idx*PDM_CSEL_W +: PDM_CSEL_W];
  endfunction : csel

  // Wait-time field to cycle count; one state is one clock.
  function automatic logic [17:0] wait_cycles(input logic [2:0] sel);
    case (sel)
      3'h0: wait_cycles = WAIT_0;
      3'h1: wait_cycles = WAIT_1;
      3'h2: wait_cycles = WAIT_2;
      3'h3: wait_cycles = WAIT_3;
      3'h4: wait_cycles = WAIT_4;
      3'h5: wait_cycles = 18'd2;
      3'h6: wait_cycles = 18'd8;
      default: wait_cycles = 18'd16;
    endcase
  endfunction : wait_cycles

  // Wake-source group in force for each mode.
  function automatic logic [PDM_SRC_W-1:0] wake_group(input pdm_mode_t m);
    case (m)
      PDM_WATCH: wake_group = PDM_GRP1;
      PDM_SUBSLEEP: wake_group = PDM_GRP2;
      PDM_SLEEP: wake_group = PDM_GRP3;
      PDM_STANDBY: wake_group = PDM_GRP4;
      default: wake_group = '0;
    endcase
  endfunction : wake_group

  // External inputs that are retained, hence ignored, per mode.
  function automatic logic [4:0] ext_retained(input pdm_mode_t m);
    case (m)
      PDM_WATCH: ext_retained = 5'h1E;
      PDM_STANDBY: ext_retained = 5'h1C;
      default: ext_retained = 5'h00;
    endcase
  endfunction : ext_retained

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  logic req;
  logic [PDM_SRC_W-1:0] ign;
  logic lowp;
  logic subm;
  logic [PDM_EV_W-1:0] ev;
  logic [31:0] wd;

  // One process computes every next value.
  always_comb begin
    s_d = s_q;
    ev = '0;
    wd = AVS_WRITEDATA;
    req = AVS_READ | AVS_WRITE;

    // Two-stage synchroniser on the asynchronous sources.
    s_d.src_m = INT_SRC;
    s_d.src_s = s_q.src_m;

    // One wait cycle per access; the answer comes from a flop.
    s_d.waitreq = !(req && s_q.waitreq);
    if (req && s_q.waitreq) begin
      case (AVS_ADDRESS)
        PDM_ADDR_CTRL: s_d.rdata = {26'h000_0000, s_q.ctrl};
        PDM_ADDR_CLKSEL: s_d.rdata = {7'h00, s_q.clksel};
        PDM_ADDR_MODE: s_d.rdata = {29'h0000_0000, s_q.mode};
        PDM_ADDR_IRQ_STAT: s_d.rdata = {29'h0000_0000, s_q.stat};
        PDM_ADDR_IRQ_MASK: s_d.rdata = {29'h0000_0000, s_q.mask};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Writes take effect at the edge that samples waitrequest low.
    if (AVS_WRITE && !s_q.waitreq) begin
      case (AVS_ADDRESS)
        PDM_ADDR_CTRL: s_d.ctrl = wd[5:0];
        PDM_ADDR_CLKSEL: s_d.clksel = wd[24:0];
        PDM_ADDR_IRQ_STAT: s_d.stat = s_q.stat & ~wd[PDM_EV_W-1:0];
        PDM_ADDR_IRQ_MASK: s_d.mask = wd[PDM_EV_W-1:0];
        default: s_d.rdata = s_q.rdata;
      endcase
    end

    ign = '0;
    ign[8 +: 5] = ext_retained(s_q.mode);
    s_d.wake = |(s_q.src_s & wake_group(s_q.mode) & ~ign);
    if (s_d.wake && !s_q.wake) begin
      ev[PDM_EV_WAKE] = 1'b1;
    end

    // Mode sequencing.
    case (s_q.mode)
      PDM_ACTIVE: begin
        if (SLEEP_REQ) begin
          ev[PDM_EV_ENTER] = 1'b1;
          if (!s_q.ctrl[PDM_CTRL_STBY_BIT]) begin
            s_d.mode = PDM_SLEEP;
          end else if (s_q.ctrl[PDM_CTRL_WATCH_BIT]) begin
            s_d.mode = PDM_WATCH;
          end else begin
            s_d.mode = PDM_STANDBY;
          end
        end
      end
      PDM_SUBACTIVE: begin
        if (SLEEP_REQ) begin
          ev[PDM_EV_ENTER] = 1'b1;
          s_d.mode = s_q.ctrl[PDM_CTRL_STBY_BIT] ? PDM_WATCH : PDM_SUBSLEEP;
        end
      end
      PDM_SLEEP: begin
        if (INT_ACCEPT && s_q.wake) begin
          s_d.mode = PDM_ACTIVE;
        end
      end
      PDM_SUBSLEEP: begin
        if (INT_ACCEPT && s_q.wake) begin
          s_d.mode = PDM_SUBACTIVE;
        end
      end
      PDM_WATCH, PDM_STANDBY: begin
        if (INT_ACCEPT && s_q.wake) begin
          if (s_q.mode == PDM_WATCH && s_q.ctrl[PDM_CTRL_SUBCLK_BIT]) begin
            s_d.mode = PDM_SUBACTIVE;
          end else begin
            s_d.mode = PDM_WAKE_WAIT;
            s_d.wait_cnt = wait_cycles(s_q.ctrl[PDM_CTRL_WSEL_LSB +: 3]);
          end
        end
      end
      PDM_WAKE_WAIT: begin
        if (s_q.wait_cnt <= 18'd1) begin
          s_d.mode = PDM_ACTIVE;
          s_d.wait_cnt = '0;
        end else begin
          s_d.wait_cnt = s_q.wait_cnt - 18'd1;
        end
      end
      default: s_d.mode = PDM_ACTIVE;
    endcase
    if ((s_d.mode == PDM_ACTIVE || s_d.mode == PDM_SUBACTIVE) && s_d.mode != s_q.mode) begin
      ev[PDM_EV_ACTIVE] = 1'b1;
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    s_d.stat = s_d.stat | ev;
    s_d.irq = |(s_d.stat & s_d.mask);

    // Clock and run controls follow the next mode.
    lowp = (s_d.mode == PDM_WATCH) || (s_d.mode == PDM_SUBACTIVE) || (s_d.mode == PDM_SUBSLEEP)
           || (s_d.mode == PDM_STANDBY);
    subm = (s_d.mode == PDM_SUBACTIVE) || (s_d.mode == PDM_SUBSLEEP);
    // system oscillator off when low power
    s_d.sys_osc = !lowp;
    s_d.sub_osc = 1'b1;
    s_d.cpu_run = (s_d.mode == PDM_ACTIVE) || (s_d.mode == PDM_SUBACTIVE);
    s_d.on_sub = subm;
    s_d.port_hiz = (s_d.mode == PDM_STANDBY);
    s_d.ext_hold = ext_retained(s_d.mode);
    s_d.aec_irq_en = !((s_d.mode == PDM_WATCH) || (s_d.mode == PDM_STANDBY));

    s_d.rst = '0;
    if (!lowp && s_d.mode != PDM_WAKE_WAIT) begin
      s_d.run_en = '1;
    end else begin
      s_d.run_en = '0;
      s_d.run_en[PDM_P_TK] = (s_d.mode != PDM_STANDBY) && (s_d.mode != PDM_WAKE_WAIT)
                             && s_q.clksel[PDM_CSEL_TBASE_BIT];
      s_d.run_en[PDM_P_AEC] = 1'b1;
      s_d.run_en[PDM_P_CAP] = subm && (csel(s_q.clksel, PDM_CSEL_CAP) == PDM_CK_EXT
                                       || csel(s_q.clksel, PDM_CSEL_CAP) == PDM_CK_W4);
      s_d.run_en[PDM_P_SERA] = subm && csel(s_q.clksel, PDM_CSEL_SERA) == PDM_CK_W2;
      s_d.run_en[PDM_P_SERB] = subm && csel(s_q.clksel, PDM_CSEL_SERB) == PDM_CK_W2;
      s_d.rst[PDM_P_SERA] = (s_d.mode == PDM_WATCH) || (s_d.mode == PDM_STANDBY);
      s_d.rst[PDM_P_SERB] = s_d.rst[PDM_P_SERA];
      s_d.run_en[PDM_P_LCD] = (subm || s_d.mode == PDM_WATCH)
                              && (csel(s_q.clksel, PDM_CSEL_LCD) == PDM_CK_W
                                  || csel(s_q.clksel, PDM_CSEL_LCD) == PDM_CK_W2
                                  || csel(s_q.clksel, PDM_CSEL_LCD) == PDM_CK_W4);
      s_d.run_en[PDM_P_WDT] = (s_d.mode == PDM_SUBACTIVE)
                              && csel(s_q.clksel, PDM_CSEL_WDT) == PDM_CK_W32;
      s_d.run_en[PDM_P_EVF] = (subm || s_d.mode == PDM_WATCH)
                              && csel(s_q.clksel, PDM_CSEL_EVF) == PDM_CK_W4;
      s_d.run_en[PDM_P_EVG] = (subm || s_d.mode == PDM_WATCH)
                              && csel(s_q.clksel, PDM_CSEL_EVG) == PDM_CK_W4;
      s_d.run_en[PDM_P_SER1] = subm && csel(s_q.clksel, PDM_CSEL_SER1) == PDM_CK_W4;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Every flop resets to a constant.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= '0;
      s_q.mode <= PDM_ACTIVE;
      s_q.ctrl <= PDM_CTRL_RESET;
      s_q.clksel <= PDM_CLKSEL_RESET;
      s_q.waitreq <= 1'b1;
      s_q.cpu_run <= 1'b1;
      s_q.sys_osc <= 1'b1;
      s_q.sub_osc <= 1'b1;
      s_q.run_en <= '1;
      s_q.aec_irq_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from flops.
  assign AVS_READDATA = s_q.rdata;
  assign AVS_WAITREQUEST = s_q.waitreq;
  assign CPU_RUN = s_q.cpu_run;
  assign CPU_ON_SUBCLK = s_q.on_sub;
  assign SYS_OSC_EN = s_q.sys_osc;
  assign SUB_OSC_EN = s_q.sub_osc;
  assign PORT_HIZ = s_q.port_hiz;
  assign RUN_EN = s_q.run_en;
  assign PERIPH_RST = s_q.rst;
  assign EXT_FLAG_HOLD = s_q.ext_hold;
  assign AEC_IRQ_EN = s_q.aec_irq_en;
  assign WAKE_REQ = s_q.wake;
  assign MODE = s_q.mode;
  assign IRQ = s_q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  property p_watch_grp;
    s_q.mode == PDM_WATCH && (s_q.src_s & ~PDM_GRP1) != '0 && (s_q.src_s & PDM_GRP1) == '0 |=> !s_q.wake;
  endproperty
  a_watch_grp: assert property (p_watch_grp) else $error("watch woke on foreign source");

  property p_sub_grp;
    s_q.mode == PDM_SUBSLEEP && (s_q.src_s & PDM_GRP2) != '0 |=> s_q.wake;
  endproperty
  a_sub_grp: assert property (p_sub_grp) else $error("subsleep missed group two source");

  property p_stby_grp;
    s_q.mode == PDM_STANDBY && (s_q.src_s & PDM_GRP4) == '0 |=> !s_q.wake;
  endproperty
  a_stby_grp: assert property (p_stby_grp) else $error("standby woke outside group four");

  property p_accept;
    s_q.mode == PDM_SLEEP && !INT_ACCEPT |=> s_q.mode == PDM_SLEEP;
  endproperty
  a_accept: assert property (p_accept) else $error("sleep left without acceptance");

  property p_hiz;
    s_q.mode == PDM_STANDBY |-> PORT_HIZ;
  endproperty
  a_hiz: assert property (p_hiz) else $error("ports not high-z in standby");

  property p_stby_sel;
    s_q.mode == PDM_ACTIVE && SLEEP_REQ && s_q.ctrl[PDM_CTRL_STBY_BIT] |=> s_q.mode inside {PDM_WATCH, PDM_STANDBY};
  endproperty
  a_stby_sel: assert property (p_stby_sel) else $error("standby select ignored");

  property p_wait;
    s_q.mode == PDM_STANDBY && INT_ACCEPT && s_q.wake && s_q.ctrl[PDM_CTRL_WSEL_LSB +: 3] == 3'h6
      |=> s_q.mode == PDM_WAKE_WAIT ##8 s_q.mode == PDM_ACTIVE;
  endproperty
  a_wait: assert property (p_wait) else $error("wake wait length wrong");

  property p_osc;
    s_q.mode inside {PDM_WATCH, PDM_STANDBY, PDM_SUBACTIVE, PDM_SUBSLEEP} |-> !SYS_OSC_EN && SUB_OSC_EN;
  endproperty
  a_osc: assert property (p_osc) else $error("system oscillator on in low power");

  property p_aec;
    s_q.mode inside {PDM_WATCH, PDM_STANDBY} |-> !AEC_IRQ_EN;
  endproperty
  a_aec: assert property (p_aec) else $error("counter interrupt enabled in watch");

  property p_bus;
    AVS_WAITREQUEST && (AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");

  c_sleep_wake: cover property (s_q.mode == PDM_SLEEP ##[1:50] s_q.mode == PDM_ACTIVE);
  c_standby_wait: cover property (s_q.mode == PDM_WAKE_WAIT ##1 s_q.mode == PDM_ACTIVE);
  c_sub_watch: cover property (s_q.mode == PDM_SUBACTIVE ##1 s_q.mode == PDM_WATCH);

endmodule : pdm_ctrl

`default_nettype wire

/* File: inc/pdm_pkg.sv */
package pdm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] PDM_ADDR_CTRL = 5'h00;
  localparam logic [4:0] PDM_ADDR_CLKSEL = 5'h04;
  localparam logic [4:0] PDM_ADDR_MODE = 5'h08;
  localparam logic [4:0] PDM_ADDR_IRQ_STAT = 5'h0C;
  localparam logic [4:0] PDM_ADDR_IRQ_MASK = 5'h10;

  // Control register fields and reset value.
  localparam int PDM_CTRL_STBY_BIT = 0;
  localparam int PDM_CTRL_WSEL_LSB = 1;
  localparam int PDM_CTRL_SUBCLK_BIT = 4;
  localparam int PDM_CTRL_WATCH_BIT = 5;
  localparam logic [5:0] PDM_CTRL_RESET = 6'h00;

  // Clock select register: eight 3-bit fields plus the time-base bit.
  localparam int PDM_CSEL_W = 3;
  localparam int PDM_CSEL_CAP = 0;
  localparam int PDM_CSEL_SERA = 1;
  localparam int PDM_CSEL_SERB = 2;
  localparam int PDM_CSEL_LCD = 3;
  localparam int PDM_CSEL_WDT = 4;
  localparam int PDM_CSEL_EVF = 5;
  localparam int PDM_CSEL_EVG = 6;
  localparam int PDM_CSEL_SER1 = 7;
  localparam int PDM_CSEL_TBASE_BIT = 24;
  localparam logic [24:0] PDM_CLKSEL_RESET = 25'h000_0000;

  // Clock select codes.
  localparam logic [2:0] PDM_CK_SYS = 3'h0;
  localparam logic [2:0] PDM_CK_W = 3'h1;
  localparam logic [2:0] PDM_CK_W2 = 3'h2;
  localparam logic [2:0] PDM_CK_W4 = 3'h3;
  localparam logic [2:0] PDM_CK_W32 = 3'h4;
  localparam logic [2:0] PDM_CK_EXT = 3'h5;

  // Interrupt status bits.
  localparam int PDM_EV_W = 3;
  localparam int PDM_EV_WAKE = 0;
  localparam int PDM_EV_ENTER = 1;
  localparam int PDM_EV_ACTIVE = 2;

  // Interrupt source vector layout.
  localparam int PDM_SRC_W = 22;
  localparam logic [21:0] PDM_SRC_TK = 22'h00_0001;
  localparam logic [21:0] PDM_SRC_CAP = 22'h00_0002;
  localparam logic [21:0] PDM_SRC_EVT = 22'h00_000C;
  localparam logic [21:0] PDM_SRC_SER = 22'h00_0070;
  localparam logic [21:0] PDM_SRC_AEC = 22'h00_0080;
  localparam logic [21:0] PDM_SRC_EXT0 = 22'h00_0100;
  localparam logic [21:0] PDM_SRC_EXT1 = 22'h00_0200;
  localparam logic [21:0] PDM_SRC_EXT2_4 = 22'h00_1C00;
  localparam logic [21:0] PDM_SRC_WKP = 22'h1F_E000;
  localparam logic [21:0] PDM_SRC_OTHER = 22'h20_0000;

  // Wake-source groups.
  localparam logic [21:0] PDM_GRP1 = PDM_SRC_TK | PDM_SRC_EVT | PDM_SRC_EXT0 | PDM_SRC_WKP;
  localparam logic [21:0] PDM_GRP2 = PDM_SRC_TK | PDM_SRC_CAP | PDM_SRC_EVT | PDM_SRC_SER | PDM_SRC_AEC
                                     | PDM_SRC_EXT0 | PDM_SRC_EXT1 | PDM_SRC_EXT2_4 | PDM_SRC_WKP;
  localparam logic [21:0] PDM_GRP3 = 22'h3F_FFFF;
  localparam logic [21:0] PDM_GRP4 = PDM_SRC_EXT0 | PDM_SRC_EXT1 | PDM_SRC_WKP;

  // Peripheral enable vector layout.
  localparam int PDM_PER_W = 12;
  localparam int PDM_P_TK = 0;
  localparam int PDM_P_CAP = 1;
  localparam int PDM_P_EVF = 2;
  localparam int PDM_P_EVG = 3;
  localparam int PDM_P_SER1 = 4;
  localparam int PDM_P_SERA = 5;
  localparam int PDM_P_SERB = 6;
  localparam int PDM_P_AEC = 7;
  localparam int PDM_P_WDT = 8;
  localparam int PDM_P_LCD = 9;

  // Operating modes.
  typedef enum logic [2:0] {
    PDM_ACTIVE, PDM_SLEEP, PDM_SUBACTIVE, PDM_SUBSLEEP, PDM_WATCH, PDM_STANDBY, PDM_WAKE_WAIT
  } pdm_mode_t;

endpackage : pdm_pkg

/* File: sim/pdm_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Stands in for the CPU core and the interrupt sources on the far side of the controller.
module pdm_cpu_model
  import pdm_pkg::*;
(
  // Clock.
  input wire logic mclk,
  // Handshake towards the controller.
  output logic sleep_req,
  output logic int_accept,
  // Interrupt sources from pins and peripherals.
  output logic [PDM_SRC_W-1:0] int_src
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // Everything starts quiet so that no request lands during reset.
  initial begin
    sleep_req = 1'b0;
    int_accept = 1'b0;
    int_src = '0;
  end

  // ----------------------------------------------------------------
  // Core actions
  // ----------------------------------------------------------------
  // A sleep instruction is a single cycle pulse launched just after an edge.
  task automatic do_sleep();
    @(posedge mclk);
    sleep_req <= 1'b1;
    @(posedge mclk);
    sleep_req <= 1'b0;
  endtask : do_sleep

  // accept before change
  // A slow core takes lat extra cycles before it accepts the interrupt.
  // The task returns at the edge that samples the pulse.
  task automatic do_accept(input int lat);
    repeat (lat) @(posedge mclk);
    @(posedge mclk);
    int_accept <= 1'b1;
    @(posedge mclk);
    int_accept <= 1'b0;
  endtask : do_accept

  // Sources are levels; a handler drops its source once serviced.
  task automatic set_src(input logic [PDM_SRC_W-1:0] v);
    @(posedge mclk);
    int_src <= v;
  endtask : set_src

endmodule : pdm_cpu_model

`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import pdm_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk, reset_n, rd, wr, wait_rq, cpu_run, on_sub, sys_osc, sub_osc, hiz, wake, irq, aec_irq;
  logic sleep_req, int_accept;
  logic [4:0] addr, flag_hold;
  logic [31:0] wdata, rdata, rv;
  logic [PDM_SRC_W-1:0] src;
  logic [PDM_PER_W-1:0] run_en, per_rst;
  logic [2:0] mode, wsel;
  int err_total, samples_checked, n, expn;

  // Short wake waits keep the run brief; code 6 keeps its fixed 8 cycles.
  pdm_ctrl #(.WAIT_0(18'd20), .WAIT_1(18'd24), .WAIT_2(18'd28), .WAIT_3(18'd32), .WAIT_4(18'd36)) pdm_ctrl_inst (
    .MCLK(mclk), .RESET_N(reset_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_rq), .SLEEP_REQ(sleep_req),
    .INT_ACCEPT(int_accept), .INT_SRC(src), .CPU_RUN(cpu_run), .CPU_ON_SUBCLK(on_sub),
    .SYS_OSC_EN(sys_osc), .SUB_OSC_EN(sub_osc), .PORT_HIZ(hiz), .RUN_EN(run_en), .PERIPH_RST(per_rst),
    .EXT_FLAG_HOLD(flag_hold), .AEC_IRQ_EN(aec_irq), .WAKE_REQ(wake), .MODE(mode), .IRQ(irq));

  pdm_cpu_model pdm_cpu_model_inst (.mclk(mclk), .sleep_req(sleep_req), .int_accept(int_accept), .int_src(src));

  // The 100 ns clock.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Prints the verdict and stops; the only place the run ends.
  task automatic end_sim();
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // Compares with case equality so that an unknown never passes.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // A wait that ran out counts as a mismatch and closes the run.
  task automatic timed_out(input string what);
    err_total++;
    $display("[FAIL] %s expected done seen timeout", what);
    end_sim();
  endtask : timed_out

  // One Avalon access; the request stands until the rising edge that samples
  // waitrequest low, where read data is taken and the request is released.
  task automatic av_xfer(input logic is_wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= is_wr;
    rd <= !is_wr;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (wait_rq === 1'b0) break;
    end
    if (k == 50) timed_out("bus");
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : av_xfer

  // Waits for a mode under a bound, then records the comparison.
  task automatic wait_mode(input logic [2:0] m);
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge mclk);
      if (mode === m) break;
    end
    if (k == 300) timed_out("mode");
    chk("mode", 32'(m), 32'(mode));
  endtask : wait_mode

  // The synchroniser plus register needs three cycles; six leaves margin.
  task automatic chk_wake(input logic e);
    repeat (6) @(negedge mclk);
    chk("wake request", 32'(e), 32'(wake));
  endtask : chk_wake

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdata = 32'h0000_0000;
    err_total = 0;
    samples_checked = 0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    chk("reset mode", 32'h0000_0000, 32'(mode));
    chk("reset run enables", 32'h0000_0FFF, 32'(run_en));
    chk("reset subclock osc", 32'h0000_0001, 32'(sub_osc));
    chk("reset system osc", 32'h0000_0001, 32'(sys_osc));
    chk("reset waitrequest", 32'h0000_0001, 32'(wait_rq));
    // Register reset values, the read-only mode register and an unmapped place.
    av_xfer(1'b0, PDM_ADDR_CTRL, 32'h0000_0000);
    chk("ctrl reset", 32'(PDM_CTRL_RESET), rv);
    av_xfer(1'b0, PDM_ADDR_CLKSEL, 32'h0000_0000);
    chk("clksel reset", 32'(PDM_CLKSEL_RESET), rv);
    av_xfer(1'b1, PDM_ADDR_MODE, 32'h0000_0005);
    av_xfer(1'b0, PDM_ADDR_MODE, 32'h0000_0000);
    chk("mode read only", 32'h0000_0000, rv);
    av_xfer(1'b1, 5'h14, 32'hFFFF_FFFF);
    av_xfer(1'b0, 5'h14, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rv);
    // Sleep: any source wakes, but only once the core accepts it.
    av_xfer(1'b1, PDM_ADDR_CTRL, 32'h0000_0000);
    pdm_cpu_model_inst.do_sleep();
    wait_mode(PDM_SLEEP);
    chk("sleep cpu halted", 32'h0000_0000, 32'(cpu_run));
    pdm_cpu_model_inst.set_src(PDM_SRC_OTHER);
    chk_wake(1'b1);
    chk("pending keeps mode", 32'(PDM_SLEEP), 32'(mode));
    pdm_cpu_model_inst.do_accept(3);
    pdm_cpu_model_inst.set_src('0);
    wait_mode(PDM_ACTIVE);
    // Interrupt status, mask and write-one-to-clear.
    av_xfer(1'b0, PDM_ADDR_IRQ_STAT, 32'h0000_0000);
    chk("status after round", 32'h0000_0007, rv);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    av_xfer(1'b1, PDM_ADDR_IRQ_MASK, 32'h0000_0002);
    @(negedge mclk);
    chk("irq unmasked", 32'h0000_0001, 32'(irq));
    av_xfer(1'b1, PDM_ADDR_IRQ_STAT, 32'h0000_0007);
    @(negedge mclk);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    av_xfer(1'b0, PDM_ADDR_IRQ_STAT, 32'h0000_0000);
    chk("status cleared", 32'h0000_0000, rv);
    // Standby, once with the long default wait and once with the 8 cycle code.
    for (int i = 0; i < 2; i++) begin
      wsel = (i == 0) ? 3'h0 : 3'h6;
      expn = (i == 0) ? 20 : 8;
      av_xfer(1'b1, PDM_ADDR_CTRL, 32'({2'b00, wsel, 1'b1}));
      pdm_cpu_model_inst.do_sleep();
      wait_mode(PDM_STANDBY);
      chk("standby port hiz", 32'h0000_0001, 32'(hiz));
      chk("standby sys osc", 32'h0000_0000, 32'(sys_osc));
      chk("standby sub osc", 32'h0000_0001, 32'(sub_osc));
      chk("standby run", 32'h0000_0080, 32'(run_en));
      chk("standby reset", 32'h0000_0060, 32'(per_rst));
      chk("standby ext hold", 32'h0000_001C, 32'(flag_hold));
      chk("standby counter irq", 32'h0000_0000, 32'(aec_irq));
      pdm_cpu_model_inst.set_src(PDM_SRC_TK | PDM_SRC_EXT2_4);
      chk_wake(1'b0);
      pdm_cpu_model_inst.do_accept(0);
      repeat (2) @(negedge mclk);
      chk("refused accept", 32'(PDM_STANDBY), 32'(mode));
      pdm_cpu_model_inst.set_src(PDM_SRC_EXT1);
      chk_wake(1'b1);
      pdm_cpu_model_inst.do_accept(0);
      n = 0;
      // Bounded in cycles, not in wait cycles, so a stuck mode cannot hang.
      for (int t = 0; t < 300 && mode !== PDM_ACTIVE; t++) begin
        @(negedge mclk);
        if (mode === PDM_WAKE_WAIT) n++;
      end
      chk("wake wait cycles", 32'(expn), 32'(n));
      pdm_cpu_model_inst.set_src('0);
      wait_mode(PDM_ACTIVE);
    end
    // Watch, then wake into subactive on the watch clock selections.
    av_xfer(1'b1, PDM_ADDR_CLKSEL, {7'h00, 1'b1, PDM_CK_SYS, PDM_CK_SYS, PDM_CK_W4, PDM_CK_W32, PDM_CK_W4,
      PDM_CK_SYS, PDM_CK_W2, PDM_CK_EXT});
    av_xfer(1'b1, PDM_ADDR_CTRL, 32'h0000_0031);
    pdm_cpu_model_inst.do_sleep();
    wait_mode(PDM_WATCH);
    chk("watch run", 32'h0000_0285, 32'(run_en));
    chk("watch reset", 32'h0000_0060, 32'(per_rst));
    chk("watch ext hold", 32'h0000_001E, 32'(flag_hold));
    chk("watch sys osc", 32'h0000_0000, 32'(sys_osc));
    chk("watch counter irq", 32'h0000_0000, 32'(aec_irq));
    pdm_cpu_model_inst.set_src(PDM_SRC_EXT1);
    chk_wake(1'b0);
    pdm_cpu_model_inst.set_src(PDM_SRC_EXT0);
    chk_wake(1'b1);
    pdm_cpu_model_inst.do_accept(1);
    pdm_cpu_model_inst.set_src('0);
    wait_mode(PDM_SUBACTIVE);
    chk("subactive cpu", 32'h0000_0001, 32'(cpu_run));
    chk("subactive subclock", 32'h0000_0001, 32'(on_sub));
    chk("subactive run", 32'h0000_03A7, 32'(run_en));
    chk("subactive reset", 32'h0000_0000, 32'(per_rst));
    // Subsleep: the watchdog stops, group two applies.
    av_xfer(1'b1, PDM_ADDR_CTRL, 32'h0000_0000);
    pdm_cpu_model_inst.do_sleep();
    wait_mode(PDM_SUBSLEEP);
    chk("subsleep run", 32'h0000_02A7, 32'(run_en));
    pdm_cpu_model_inst.set_src(PDM_SRC_OTHER);
    chk_wake(1'b0);
    pdm_cpu_model_inst.set_src(PDM_SRC_AEC);
    chk_wake(1'b1);
    pdm_cpu_model_inst.do_accept(0);
    pdm_cpu_model_inst.set_src('0);
    wait_mode(PDM_SUBACTIVE);
    end_sim();
  end

endmodule : tb_top

`default_nettype wire
